// ==== verilog/clock_startup_pkg.sv ====
package clock_startup_pkg;
   // Register offsets
   localparam logic [7:0] rx_dbl_ctrl_addr = 8'h39;
   localparam logic [7:0] rx_dbl_offset_addr = 8'h3B;
   localparam logic [7:0] rx_dbl_tap_addr = 8'h3C;
   localparam logic [7:0] dll_enable_addr = 8'h60;
   localparam logic [7:0] clk_drive_addr = 8'h63;
   localparam logic [7:0] dcs_ctrl_addr = 8'h66;
   localparam logic [7:0] tx_src_div_addr = 8'h71;
   localparam logic [7:0] dll_mult_lock_addr = 8'h72;
   localparam logic [7:0] dll_reset_addr = 8'h75;
   localparam logic [7:0] aux_chan_addr = 8'h77;
   localparam logic [7:0] aux_res_hi_addr = 8'h78;
   localparam logic [7:0] aux_res_lo_addr = 8'h79;
   localparam logic [7:0] aux_enable_addr = 8'h7A;
   localparam logic [7:0] temp_enable_addr = 8'h7B;
   // Field positions
   localparam int dll_enable_bit = 7;
   localparam int dll_lock_bit = 7;
   localparam int dll_reset_bit = 3;
   localparam int tx_src_dll_bit = 6;
   localparam int tx_ref_en_bit = 4;
   localparam int tx_doubler_bit = 5;
   localparam int rx_dbl_sel_bit = 1;
   localparam int rx_dbl_reset_bit = 7;
   localparam int dcs_bypass_bit = 2;
   localparam int aux_start_bit = 7;
   localparam int aux_enable_bit = 7;
   localparam int temp_enable_bit = 7;
   // Reset values
   localparam logic [7:0] reg_reset_value = 8'h00;
   localparam logic [7:0] rx_offset_reset_value = 8'h5D;
   localparam logic [6:0] mult_reset_value = 7'h00;
   // Timing: lock settles, and a conversion ends, after this many reference cycles
   localparam int dll_lock_cycles = 16;
   localparam int aux_conv_cycles = 32;

   // Register access port, carrying both the write and the read strobe
   typedef struct packed {
      logic wr;
      logic rd;
      logic [7:0] addr;
      logic [7:0] wdata;
   } reg_req_t;

   // Clock plan seen by the clock network
   typedef struct packed {
      logic [6:0] mult_field;
      logic [7:0] mult_factor;
      logic [3:0] div_n;
      logic tx_from_dll;
      logic rx_doubler_on;
      logic tx_doubler_on;
      logic dcs_bypass;
      logic rx_ddr;
      logic tx_ddr;
   } clock_plan_t;
endpackage

// ==== verilog/clock_startup_config.sv ====
// Function
// RL1 - Host enables DLL, sources transmit clock from it
// RL2 - Multiplication equals multiplier field plus one
// RL3 - Multiplied clock divided by programmed N
// RL4 - Host pulses DLL reset through register
// RL5 - Bit 7 of multiplier register reads lock
// RL6 - Data buses start in single data rate
// RL7 - Receive doubler doubles main clock when enabled
// RL8 - Transmit doubler output selectable for output clock
// RL9 - Host enables doublers above 15 MHz
// RL10 - Host bypasses stabilizer below 75 MHz
// RL11 - Host programs receive doubler tap, select, offset
// RL12 - Host pulses receive doubler reset
// RL13 - Host sets receive clock drive strength
// RL14 - Host enables housekeeping converter and starts sampling
// RL15 - Twelve-bit result split across two registers
// RL16 - Host polls lock before using transmit clock
`timescale 1ns/10ps
module clock_startup_config #(
   parameter int lock_cycles = clock_startup_pkg::dll_lock_cycles,
   parameter int conv_cycles = clock_startup_pkg::aux_conv_cycles
) (
   // Clock and reset
   input wire logic clk,
   input wire logic reset,
   // Serial port register access, already deserialised
   input wire clock_startup_pkg::reg_req_t req,
   output logic [7:0] rdata,
   // Analog status from the clock and converter macros
   input wire logic dll_phase_ok,
   input wire logic [11:0] aux_sample,
   // Clock network and converter control
   output clock_startup_pkg::clock_plan_t plan,
   output logic dll_run,
   output logic dll_reset_out,
   output logic rx_doubler_reset,
   output logic [7:0] rx_doubler_tap,
   output logic [7:0] rx_doubler_offset,
   output logic [7:0] clock_drive,
   output logic aux_enable_out,
   output logic temp_sensor_on,
   output logic [3:0] aux_channel
);
   // Control registers
   logic [7:0] rx_ctrl_q, rx_ctrl_d;
   logic [7:0] rx_off_q, rx_off_d;
   logic [7:0] rx_tap_q, rx_tap_d;
   logic [7:0] dll_en_q, dll_en_d;
   logic [7:0] drive_q, drive_d;
   logic [7:0] dcs_q, dcs_d;
   logic [7:0] tx_src_q, tx_src_d;
   // Multiplier field only; the top bit of that offset is the lock flag
   logic [6:0] mult_q, mult_d;
   logic [7:0] dll_rst_q, dll_rst_d;
   logic [7:0] aux_chan_q, aux_chan_d;
   logic [7:0] aux_en_q, aux_en_d;
   logic [7:0] temp_en_q, temp_en_d;

   // Register writes
   always_comb begin
      rx_ctrl_d = rx_ctrl_q;
      rx_off_d = rx_off_q;
      rx_tap_d = rx_tap_q;
      dll_en_d = dll_en_q;
      drive_d = drive_q;
      dcs_d = dcs_q;
      tx_src_d = tx_src_q;
      mult_d = mult_q;
      dll_rst_d = dll_rst_q;
      aux_chan_d = aux_chan_q;
      aux_en_d = aux_en_q;
      temp_en_d = temp_en_q;
      // Result and unmapped offsets fall to the default and change nothing
      if (req.wr) begin
         unique case (req.addr)
            clock_startup_pkg::rx_dbl_ctrl_addr: rx_ctrl_d = req.wdata; // [RL12]
            clock_startup_pkg::rx_dbl_offset_addr: rx_off_d = req.wdata;
            clock_startup_pkg::rx_dbl_tap_addr: rx_tap_d = req.wdata;
            clock_startup_pkg::dll_enable_addr: dll_en_d = req.wdata;
            clock_startup_pkg::clk_drive_addr: drive_d = req.wdata;
            clock_startup_pkg::dcs_ctrl_addr: dcs_d = req.wdata;
            clock_startup_pkg::tx_src_div_addr: tx_src_d = req.wdata;
            clock_startup_pkg::dll_mult_lock_addr: mult_d = req.wdata[6:0]; // Lock bit read only
            clock_startup_pkg::dll_reset_addr: dll_rst_d = req.wdata;
            clock_startup_pkg::aux_chan_addr: aux_chan_d = req.wdata;
            clock_startup_pkg::aux_enable_addr: aux_en_d = req.wdata;
            clock_startup_pkg::temp_enable_addr: temp_en_d = req.wdata;
            default: ;
         endcase
      end
   end

   // Registers hold until rewritten; reset restores the defaults
   always_ff @(posedge clk) begin
      if (reset) begin
         rx_ctrl_q <= clock_startup_pkg::reg_reset_value;
         rx_off_q <= clock_startup_pkg::rx_offset_reset_value;
         rx_tap_q <= clock_startup_pkg::reg_reset_value;
         dll_en_q <= clock_startup_pkg::reg_reset_value;
         drive_q <= clock_startup_pkg::reg_reset_value;
         dcs_q <= clock_startup_pkg::reg_reset_value;
         tx_src_q <= clock_startup_pkg::reg_reset_value;
         mult_q <= clock_startup_pkg::mult_reset_value;
         dll_rst_q <= clock_startup_pkg::reg_reset_value;
         aux_chan_q <= clock_startup_pkg::reg_reset_value;
         aux_en_q <= clock_startup_pkg::reg_reset_value;
         temp_en_q <= clock_startup_pkg::reg_reset_value;
      end else begin
         rx_ctrl_q <= rx_ctrl_d;
         rx_off_q <= rx_off_d;
         rx_tap_q <= rx_tap_d;
         dll_en_q <= dll_en_d;
         drive_q <= drive_d;
         dcs_q <= dcs_d;
         tx_src_q <= tx_src_d;
         mult_q <= mult_d;
         dll_rst_q <= dll_rst_d;
         aux_chan_q <= aux_chan_d;
         aux_en_q <= aux_en_d;
         temp_en_q <= temp_en_d;
      end
   end

   // DLL lock tracking: lock only after a settled, enabled, released loop
   logic dll_active;
   logic dll_reprogram;
   logic lock_done;
   // Sixteen bits allow settling counts up to 65535 cycles
   logic [15:0] lock_cnt_q, lock_cnt_d;
   logic locked_q, locked_d;
   assign dll_active = dll_en_q[clock_startup_pkg::dll_enable_bit]
      & ~dll_rst_q[clock_startup_pkg::dll_reset_bit] & dll_phase_ok;
   // A new multiplier or clock source unsettles the loop, so counting restarts
   assign dll_reprogram = req.wr && (req.addr == clock_startup_pkg::dll_mult_lock_addr
      || req.addr == clock_startup_pkg::tx_src_div_addr);
   // Counted stand-in for the analog settling time; the real loop may differ
   assign lock_done = lock_cnt_q == 16'(lock_cycles - 1);

   always_comb begin
      lock_cnt_d = lock_cnt_q;
      locked_d = locked_q;
      if (!dll_active || dll_reprogram) begin
         lock_cnt_d = 16'h0000; // Reprogramming drops lock
         locked_d = 1'b0;
      end else if (lock_done) begin
         locked_d = 1'b1; // [RL5]
      end else begin
         lock_cnt_d = lock_cnt_q + 16'h0001;
      end
   end

   // Lock state
   always_ff @(posedge clk) begin
      if (reset) begin
         lock_cnt_q <= 16'h0000;
         locked_q <= 1'b0;
      end else begin
         lock_cnt_q <= lock_cnt_d;
         locked_q <= locked_d;
      end
   end

   // Housekeeping converter: sample captured after a fixed conversion time
   logic sampling;
   logic conv_done;
   logic [15:0] conv_cnt_q, conv_cnt_d;
   logic [11:0] result_q, result_d;
   assign sampling = aux_chan_q[clock_startup_pkg::aux_start_bit]
      & aux_en_q[clock_startup_pkg::aux_enable_bit];
   // End of one conversion window; the result holds while sampling is off
   assign conv_done = conv_cnt_q == 16'(conv_cycles - 1);

   always_comb begin
      conv_cnt_d = conv_cnt_q;
      result_d = result_q;
      if (!sampling) begin
         conv_cnt_d = 16'h0000;
      end else if (conv_done) begin
         conv_cnt_d = 16'h0000;
         result_d = aux_sample; // Result refreshes each conversion
      end else begin
         conv_cnt_d = conv_cnt_q + 16'h0001;
      end
   end

   // Converter state
   always_ff @(posedge clk) begin
      if (reset) begin
         conv_cnt_q <= 16'h0000;
         result_q <= 12'h000;
      end else begin
         conv_cnt_q <= conv_cnt_d;
         result_q <= result_d;
      end
   end

   // Read data, registered one cycle after the read strobe
   logic [7:0] rdata_d;
   logic [7:0] lock_view;
   logic [7:0] result_high;
   logic [7:0] result_low;
   // Lock flag shares its byte with the writable multiplier field
   assign lock_view = {locked_q, mult_q}; // [RL5]
   // Bytes are read apart, so a refresh between the two reads can tear them
   assign result_high = result_q[11:4]; // [RL15]
   assign result_low = {result_q[3:0], 4'h0}; // [RL15]
   always_comb begin
      rdata_d = 8'h00;
      if (req.rd) begin
         unique case (req.addr)
            clock_startup_pkg::rx_dbl_ctrl_addr: rdata_d = rx_ctrl_q;
            clock_startup_pkg::rx_dbl_offset_addr: rdata_d = rx_off_q;
            clock_startup_pkg::rx_dbl_tap_addr: rdata_d = rx_tap_q;
            clock_startup_pkg::dll_enable_addr: rdata_d = dll_en_q;
            clock_startup_pkg::clk_drive_addr: rdata_d = drive_q;
            clock_startup_pkg::dcs_ctrl_addr: rdata_d = dcs_q;
            clock_startup_pkg::tx_src_div_addr: rdata_d = tx_src_q;
            clock_startup_pkg::dll_mult_lock_addr: rdata_d = lock_view; // [RL5]
            clock_startup_pkg::dll_reset_addr: rdata_d = dll_rst_q;
            clock_startup_pkg::aux_chan_addr: rdata_d = aux_chan_q;
            clock_startup_pkg::aux_res_hi_addr: rdata_d = result_high; // [RL15]
            clock_startup_pkg::aux_res_lo_addr: rdata_d = result_low; // [RL15]
            clock_startup_pkg::aux_enable_addr: rdata_d = aux_en_q;
            clock_startup_pkg::temp_enable_addr: rdata_d = temp_en_q;
            default: rdata_d = 8'h00; // Unmapped reads return zero
         endcase
      end
   end

   // Transmit source register fields
   logic tx_src_dll;
   logic tx_ref_en;
   logic tx_dbl_sel;
   logic [3:0] tx_div_n;
   assign tx_src_dll = tx_src_q[clock_startup_pkg::tx_src_dll_bit];
   assign tx_ref_en = tx_src_q[clock_startup_pkg::tx_ref_en_bit];
   assign tx_dbl_sel = tx_src_q[clock_startup_pkg::tx_doubler_bit];
   assign tx_div_n = tx_src_q[3:0];

   // Output plan derived from the registers
   clock_startup_pkg::clock_plan_t plan_d;
   always_comb begin
      plan_d.mult_field = mult_q;
      plan_d.mult_factor = {1'b0, mult_q} + 8'h01; // [RL2]
      plan_d.div_n = tx_div_n; // [RL3]
      plan_d.tx_from_dll = tx_src_dll & tx_ref_en; // Loop clock needs its reference too
      plan_d.rx_doubler_on = rx_ctrl_q[clock_startup_pkg::rx_dbl_sel_bit]; // [RL7]
      plan_d.tx_doubler_on = tx_dbl_sel; // [RL8]
      plan_d.dcs_bypass = dcs_q[clock_startup_pkg::dcs_bypass_bit];
      // Double rate modes are not decoded here, so both buses stay single rate
      plan_d.rx_ddr = 1'b0; // [RL6]
      plan_d.tx_ddr = 1'b0; // [RL6]
   end

   // Next values of the registered outputs
   logic dll_run_d;
   logic dll_reset_out_d;
   logic rx_doubler_reset_d;
   logic [7:0] rx_doubler_tap_d;
   logic [7:0] rx_doubler_offset_d;
   logic [7:0] clock_drive_d;
   logic aux_enable_out_d;
   logic temp_sensor_on_d;
   logic [3:0] aux_channel_d;
   always_comb begin
      dll_run_d = dll_en_q[clock_startup_pkg::dll_enable_bit];
      dll_reset_out_d = dll_rst_q[clock_startup_pkg::dll_reset_bit];
      rx_doubler_reset_d = rx_ctrl_q[clock_startup_pkg::rx_dbl_reset_bit];
      rx_doubler_tap_d = rx_tap_q;
      rx_doubler_offset_d = rx_off_q;
      clock_drive_d = drive_q;
      aux_enable_out_d = aux_en_q[clock_startup_pkg::aux_enable_bit];
      temp_sensor_on_d = temp_en_q[clock_startup_pkg::temp_enable_bit];
      aux_channel_d = aux_chan_q[3:0];
   end

   // Outputs registered so every pin comes from a flip-flop
   always_ff @(posedge clk) begin
      if (reset) begin
         rdata <= 8'h00;
         plan <= '0;
         dll_run <= 1'b0;
         dll_reset_out <= 1'b0;
         rx_doubler_reset <= 1'b0;
         rx_doubler_tap <= 8'h00;
         rx_doubler_offset <= 8'h00;
         clock_drive <= 8'h00;
         aux_enable_out <= 1'b0;
         temp_sensor_on <= 1'b0;
         aux_channel <= 4'h0;
      end else begin
         rdata <= rdata_d;
         plan <= plan_d;
         dll_run <= dll_run_d;
         dll_reset_out <= dll_reset_out_d;
         rx_doubler_reset <= rx_doubler_reset_d;
         rx_doubler_tap <= rx_doubler_tap_d;
         rx_doubler_offset <= rx_doubler_offset_d;
         clock_drive <= clock_drive_d;
         aux_enable_out <= aux_enable_out_d;
         temp_sensor_on <= temp_sensor_on_d;
         aux_channel <= aux_channel_d;
      end
   end
endmodule

// ==== verification/clock_startup_monitor.sv ====
`timescale 1ns/10ps
module clock_startup_monitor (
   // Clock and reset
   input wire logic clk,
   input wire logic reset,
   // Register port
   input wire clock_startup_pkg::reg_req_t req,
   input wire logic [7:0] rdata,
   // Status and controls
   input wire logic dll_phase_ok,
   input wire logic [11:0] aux_sample,
   input wire clock_startup_pkg::clock_plan_t plan,
   input wire logic dll_run,
   input wire logic dll_reset_out,
   input wire logic rx_doubler_reset,
   input wire logic [7:0] rx_doubler_tap,
   input wire logic [7:0] rx_doubler_offset,
   input wire logic [7:0] clock_drive,
   input wire logic aux_enable_out,
   input wire logic temp_sensor_on,
   input wire logic [3:0] aux_channel
);
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (reset);
   // Requests to one offset
   sequence s_wr(logic [7:0] a);
      req.wr && req.addr == a;
   endsequence
   sequence s_rd(logic [7:0] a);
      req.rd && req.addr == a;
   endsequence
   // Control outputs follow writes two cycles later
   a_dll_enable_follow: assert property (s_wr(8'h60) |-> ##2
      dll_run == $past(req.wdata[7], 2))
      else $error("dll run wrong");
   a_mult_field_follow: assert property (s_wr(8'h72) |-> ##2
      plan.mult_field == $past(req.wdata[6:0], 2))
      else $error("mult field wrong");
   a_mult_factor_sum: assert property (plan.mult_field != 7'h00 |->
      plan.mult_factor == {1'b0, plan.mult_field} + 8'h01)
      else $error("mult factor wrong");
   a_tx_source_follow: assert property (s_wr(8'h71) |-> ##2
      plan.div_n == $past(req.wdata[3:0], 2) && plan.tx_doubler_on == $past(req.wdata[5], 2))
      else $error("tx source wrong");
   a_dll_reset_follow: assert property (s_wr(8'h75) |-> ##2
      dll_reset_out == $past(req.wdata[3], 2))
      else $error("dll reset wrong");
   a_lock_needs_phase: assert property ((!dll_phase_ok)[*3] ##0 s_rd(8'h72) |=>
      !rdata[7])
      else $error("lock without phase");
   a_sdr_fixed: assert property (!plan.rx_ddr && !plan.tx_ddr)
      else $error("bus not sdr");
   a_rx_doubler_follow: assert property (s_wr(8'h39) |-> ##2
      plan.rx_doubler_on == $past(req.wdata[1], 2) && rx_doubler_reset == $past(req.wdata[7], 2))
      else $error("rx doubler wrong");
   a_aux_enable_follow: assert property (s_wr(8'h7A) |-> ##2
      aux_enable_out == $past(req.wdata[7], 2))
      else $error("aux enable wrong");
   a_low_nibble_zero: assert property (s_rd(8'h79) |=> rdata[3:0] == 4'h0)
      else $error("low nibble not zero");
endmodule

// ==== verification/clock_startup_host.sv ====
`timescale 1ns/10ps
module clock_startup_host (
   // Clock and read data
   input wire logic clk,
   input wire logic [7:0] rdata,
   // Request
   output clock_startup_pkg::reg_req_t req
);
   initial req = '0;
   // One strobe cycle per access, changed 1 ns after the edge
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge clk) #1 req = '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
      @(posedge clk) #1 req = '0;
   endtask
   // Read data stands only in the cycle after the read edge
   task automatic rd(input logic [7:0] a, output logic [7:0] d);
      @(posedge clk) #1 req = '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'h00};
      @(posedge clk) #1 d = rdata;
      req = '0;
   endtask
endmodule

// ==== verification/clock_startup_config_test.sv ====
`timescale 1ns/10ps
module clock_startup_config_test;
   logic clk, reset, dll_phase_ok, dll_run, dll_reset_out, rx_doubler_reset;
   logic aux_enable_out, temp_sensor_on;
   logic [11:0] aux_sample;
   logic [7:0] rdata, rx_doubler_tap, rx_doubler_offset, clock_drive, d;
   logic [3:0] aux_channel;
   clock_startup_pkg::reg_req_t req;
   clock_startup_pkg::clock_plan_t plan;
   int fail_count = 0;
   int cmp_count = 0;
   int cycles = 0;
   int n;
   clock_startup_config #(.lock_cycles(4), .conv_cycles(4)) uut (.clk(clk), .reset(reset),
      .req(req), .rdata(rdata), .dll_phase_ok(dll_phase_ok), .aux_sample(aux_sample),
      .plan(plan), .dll_run(dll_run), .dll_reset_out(dll_reset_out),
      .rx_doubler_reset(rx_doubler_reset), .rx_doubler_tap(rx_doubler_tap),
      .rx_doubler_offset(rx_doubler_offset), .clock_drive(clock_drive),
      .aux_enable_out(aux_enable_out), .temp_sensor_on(temp_sensor_on),
      .aux_channel(aux_channel));
   clock_startup_host host (.clk(clk), .rdata(rdata), .req(req));
   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      cmp_count++;
      if (got !== exp) begin
         fail_count++;
         $display("[ERR] %0t got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic wt(input int c);
      repeat (c) @(posedge clk);
      #1;
   endtask
   task automatic report_and_stop();
      if (fail_count == 0 && cmp_count > 0) $display("[ PASS ]");
      else $display("[ FAIL ]");
      $finish;
   endtask
   // Reset state, reset values and an unmapped read
   task automatic t_reset_values();
      chk({6'h00, plan.rx_ddr, plan.tx_ddr}, 8'h00);
      wt(2); // Quiet phase detector for three edges ahead of the lock read
      host.rd(8'h72, d);
      chk(d, 8'h00);
      host.rd(8'h3B, d);
      chk(d, 8'h5D);
      host.rd(8'h10, d);
      chk(d, 8'h00);
   endtask
   // Full DLL start-up, then lock polled with a bounded count
   task automatic t_dll();
      host.wr(8'h60, 8'h80);
      host.wr(8'h71, 8'h53);
      host.wr(8'h72, 8'h09);
      wt(2);
      chk(plan.mult_factor, 8'h0A);
      chk({4'h0, plan.div_n}, 8'h03);
      chk({6'h00, plan.tx_from_dll, dll_run}, 8'h03);
      host.wr(8'h75, 8'h08);
      wt(2);
      chk({7'h00, dll_reset_out}, 8'h01);
      host.wr(8'h75, 8'h00);
      dll_phase_ok = 1'b1;
      host.rd(8'h72, d);
      chk(d, 8'h09);
      n = 0;
      do begin
         host.rd(8'h72, d);
         n++;
      end while (d[7] !== 1'b1 && n < 20);
      chk(d, 8'h89);
   endtask
   // Receive doubler set-up with its reset pulse, then transmit doubler
   task automatic t_rxdbl();
      host.wr(8'h3C, 8'h00);
      host.wr(8'h39, 8'h02);
      host.wr(8'h66, 8'h04);
      host.wr(8'h3B, 8'h55);
      host.wr(8'h39, 8'h82);
      wt(2);
      chk({7'h00, rx_doubler_reset}, 8'h01);
      host.wr(8'h39, 8'h02);
      host.wr(8'h63, 8'h08);
      host.wr(8'h71, 8'h73);
      wt(2);
      chk({5'h00, rx_doubler_reset, plan.rx_doubler_on, plan.dcs_bypass}, 8'h03);
      chk({7'h00, plan.tx_doubler_on}, 8'h01);
      chk(rx_doubler_offset, 8'h55);
      chk(rx_doubler_tap, 8'h00);
      chk(clock_drive, 8'h08);
   endtask
   // Temperature sampling; a write to the read-only result is ignored
   task automatic t_aux();
      host.wr(8'h77, 8'h03);
      host.wr(8'h7A, 8'h80);
      host.wr(8'h7B, 8'h80);
      host.wr(8'h77, 8'h83);
      wt(2);
      chk({aux_enable_out, temp_sensor_on, 2'h0, aux_channel}, 8'hC3);
      wt(12);
      host.wr(8'h78, 8'h00);
      host.rd(8'h78, d);
      chk(d, 8'hAB);
      host.rd(8'h79, d);
      chk(d, 8'hC0);
   endtask
   initial begin
      clk = 1'b0;
      forever #25 clk = ~clk;
   end
   // About 80 cycles expected; ceiling well above that
   always @(posedge clk) begin
      cycles++;
      if (cycles == 3000) begin
         fail_count++;
         report_and_stop();
      end
   end
   initial begin
      reset = 1'b1;
      dll_phase_ok = 1'b0;
      aux_sample = 12'hABC;
      repeat (5) @(posedge clk);
      #1 reset = 1'b0;
      t_reset_values();
      t_dll();
      t_rxdbl();
      t_aux();
      report_and_stop();
   end
endmodule
bind clock_startup_config clock_startup_monitor mon (.clk(clk), .reset(reset), .req(req),
   .rdata(rdata), .dll_phase_ok(dll_phase_ok), .aux_sample(aux_sample), .plan(plan),
   .dll_run(dll_run), .dll_reset_out(dll_reset_out), .rx_doubler_reset(rx_doubler_reset),
   .rx_doubler_tap(rx_doubler_tap), .rx_doubler_offset(rx_doubler_offset),
   .clock_drive(clock_drive), .aux_enable_out(aux_enable_out),
   .temp_sensor_on(temp_sensor_on), .aux_channel(aux_channel));
